//--- include/eeprom_row_pkg.sv
// Purpose: constants and state type of the data eeprom row programmer
// Assumes: 32-bit AXI4-Lite register bus, byte-wide eeprom, 25 MHz clock
// Notes: Notes on behaviour follow below

package eeprom_row_pkg;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int MEM_BYTES = 256;
  localparam int ROW_BYTES = 32;
  localparam int ROW_W = 3; // number of rows is 8
  localparam int LANE_W = 5; // byte position within a row
  localparam int ADDR_W = 12;

  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] CTRL_STATUS_ADDR = 12'h030;
  localparam logic [11:0] OPTION_ADDR = 12'h034;
  localparam logic [1:0] EE_REGION = 2'h1; // addr[11:10], base 0x400

  // ***************************************************************
  // fields and reset values
  // ***************************************************************
  localparam int PGM_BIT = 0;
  localparam int LAT_BIT = 1;
  localparam int ROP_BIT = 0;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] LATCH_CLEAR = 8'hff; // neutral value for AND
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int PROG_TIME_NS = 5000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // complete state of the block, registered in one place
  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] mem; // eeprom cells
    logic [ROW_BYTES-1:0][7:0] latch; // write latches
    logic [ROW_BYTES-1:0] latch_used; // latch holds data
    logic [ROW_W-1:0] row; // row of the last capture
    logic lat; // latch_mode_bit
    logic pgm; // program_start_bit
    logic [31:0] count; // cycles left in programming
    logic rop; // readout_protect_option
    logic wait_state;
    logic halt_state;
    logic erase_req;
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ee_state_type;

endpackage

//--- verilog/data_eeprom_row_programmer.sv
// Purpose: data eeprom with row latches, timed programming, AXI4-Lite
// Assumes: wait/halt requests come from the cpu on the same clock
// Notes: eeprom byte i sits at byte address 0x400 + 4*i, low 8 bits
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module data_eeprom_row_programmer
  import eeprom_row_pkg::*;
#(
  parameter int PROG_LEN = eeprom_row_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // axi4-lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [eeprom_row_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [eeprom_row_pkg::ADDR_W-1:0] araddr_i,
  input wire logic [2:0] arprot_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // cpu power state requests
  input wire logic wait_for_interrupt_instr_i,
  input wire logic active_halt_i,
  input wire logic halt_i,
  // status
  output logic wait_state_o,
  output logic halt_state_o,
  output logic prog_busy_o,
  output logic flash_erase_req_o
);
  import eeprom_row_pkg::*;

  // ***************************************************************
  // state and decode helpers
  // ***************************************************************
  ee_state_type st; // registered state
  ee_state_type next_st; // next value of the state
  logic wr_go; // both write halves held, response slot free
  logic wr_ee; // held write targets the eeprom area
  logic [7:0] wr_idx; // eeprom byte index of held write
  logic [LANE_W-1:0] wr_lane; // latch chosen by held write
  logic rd_go; // read address taken this cycle
  logic rd_ee; // read targets the eeprom area
  logic [7:0] rd_idx; // eeprom byte index of the read
  logic [7:0] rd_mem_byte; // cell under the read address
  logic prog_done; // last cycle of the programming timer
  logic wait_req; // cpu asks for wait or active-halt
  logic capture; // a write lands in a latch this cycle
  logic [7:0] lane_val; // latch contents before capture

  // protection level is unused; every access is accepted alike
  assign wr_idx = st.awaddr[9:2];
  assign wr_lane = wr_idx[LANE_W-1:0];
  assign wr_ee = (st.awaddr[11:10] == EE_REGION);
  assign wr_go = st.aw_full & st.w_full & ~st.bvalid;
  // read decode works on the live address, taken at the same edge
  assign rd_go = arvalid_i & st.arready;
  assign rd_idx = araddr_i[9:2];
  assign rd_ee = (araddr_i[11:10] == EE_REGION);
  assign rd_mem_byte = st.mem[rd_idx];
  assign lane_val = st.latch[wr_lane];
  // active-halt is treated exactly like a wait request
  assign wait_req = wait_for_interrupt_instr_i | active_halt_i;
  // counter hits one on the final cycle of the loaded duration
  assign prog_done = st.pgm & (st.count == 32'h00000001)
    & ~halt_i;
  // writes latch only in write mode, idle, unprotected, not halted
  assign capture = wr_go & st.wlane0 & wr_ee & ~st.rop & st.lat
    & ~st.pgm & ~halt_i;

  // ***************************************************************
  // next state
  // ***************************************************************
  // one combinational pass: bus channels, control, timer, power
  always_comb begin
    next_st = st;
    next_st.erase_req = 1'b0;

    // write address and data are taken independently
    if (awvalid_i && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_full = 1'b1;
      next_st.awaddr = awaddr_i;
    end
    if (wvalid_i && st.wready) begin
      next_st.wready = 1'b0;
      next_st.w_full = 1'b1;
      next_st.wbyte = wdata_i[7:0];
      next_st.wlane0 = wstrb_i[0];
    end
    // response accepted: reopen both write channels
    if (st.bvalid && bready_i) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // programming timer runs on its own once started
    if (st.pgm && !prog_done) begin
      next_st.count = st.count - 32'h00000001;
    end
    if (prog_done) begin
      // commit each used latch into the last captured row
      for (int i = 0; i < ROW_BYTES; i++) begin
        if (st.latch_used[i]) begin
          next_st.mem[{st.row, i[LANE_W-1:0]}] = st.latch[i];
        end
      end
      next_st.pgm = 1'b0;
      next_st.lat = 1'b0;
      next_st.count = 32'h00000000;
    end

    // execute a held write
    if (wr_go) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      // byte lane 0 off: nothing below changes; answered OKAY unless protected eeprom or undecoded
      if (st.awaddr == CTRL_STATUS_ADDR) begin
        // ignored in the very cycle the timer finishes
        if (st.wlane0 && !prog_done) begin
          if (st.pgm) begin
            // latch bit may not be cleared while busy
            if (!st.wbyte[PGM_BIT]) begin
              // early clear abandons the row, cells untouched
              next_st.pgm = 1'b0;
              next_st.count = 32'h00000000;
            end
          end else begin
            next_st.lat = st.wbyte[LAT_BIT];
            // a pending wait request refuses the start, so wait is at once
            if (st.wbyte[PGM_BIT] && st.wbyte[LAT_BIT] && !halt_i
                && !st.wait_state && !wait_req) begin
              next_st.pgm = 1'b1;
              next_st.count = 32'(PROG_LEN);
            end
          end
        end
      end else if (st.awaddr == OPTION_ADDR) begin
        if (st.wlane0) begin
          next_st.rop = st.wbyte[ROP_BIT];
          // removing protection wipes eeprom and asks for flash erase
          if (st.rop && !st.wbyte[ROP_BIT]) begin
            for (int j = 0; j < MEM_BYTES; j++) begin
              next_st.mem[j] = ERASED_BYTE;
            end
            next_st.erase_req = 1'b1;
            next_st.pgm = 1'b0;
            next_st.lat = 1'b0;
            next_st.count = 32'h00000000;
          end
        end
      end else if (wr_ee) begin
        if (st.rop) begin
          next_st.bresp = RESP_SLVERR;
        end else if (capture) begin
          // latched data accumulate, never replaced
          next_st.latch[wr_lane] = lane_val & st.wbyte;
          next_st.latch_used[wr_lane] = 1'b1;
          next_st.row = wr_idx[7:LANE_W];
        end
      end else begin
        next_st.bresp = RESP_DECERR;
      end
    end

    // halt abandons any running cycle at once
    if (halt_i) begin
      next_st.pgm = 1'b0;
      next_st.count = 32'h00000000;
    end
    // halt status simply follows the request one cycle late
    next_st.halt_state = halt_i;

    // falling latch bit empties the latches, whatever caused it
    if (st.lat && !next_st.lat) begin
      next_st.latch = {ROW_BYTES{LATCH_CLEAR}};
      next_st.latch_used = '0;
    end

    // wait entry deferred while a cycle is still running
    next_st.wait_state = wait_req & ~next_st.pgm;

    // read channel, answered one cycle after the address
    if (rd_go) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h00000000;
      if (araddr_i == CTRL_STATUS_ADDR) begin
        // bits 7:2 forced low
        next_st.rdata[LAT_BIT] = st.lat;
        next_st.rdata[PGM_BIT] = st.pgm;
      end else if (araddr_i == OPTION_ADDR) begin
        next_st.rdata[ROP_BIT] = st.rop;
      end else if (rd_ee) begin
        // latch contents have no read path at all
        if (st.rop) begin
          next_st.rresp = RESP_SLVERR;
        end else if (st.lat) begin
          next_st.rresp = RESP_SLVERR;
        end else begin
          next_st.rdata[7:0] = rd_mem_byte;
        end
      end else begin
        next_st.rresp = RESP_DECERR;
      end
    end
    if (st.rvalid && rready_i) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // reset models power-on; every cell returns to the erased value, a running row is lost
    if (rst_i) begin
      next_st = '0;
      next_st.mem = {MEM_BYTES{ERASED_BYTE}};
      next_st.latch = {ROW_BYTES{LATCH_CLEAR}};
      next_st.lat = CTRL_STATUS_RESET[LAT_BIT];
      next_st.pgm = CTRL_STATUS_RESET[PGM_BIT];
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // single register for the whole state; reset handled above
  always_ff @(posedge clk_sys_i) begin
    st <= next_st;
  end

  // ***************************************************************
  // outputs, all straight from the state register
  // ***************************************************************
  assign awready_o = st.awready;
  assign wready_o = st.wready;
  assign bvalid_o = st.bvalid;
  assign bresp_o = st.bresp;
  assign arready_o = st.arready;
  assign rvalid_o = st.rvalid;
  assign rdata_o = st.rdata;
  assign rresp_o = st.rresp;
  assign wait_state_o = st.wait_state;
  assign halt_state_o = st.halt_state;
  assign prog_busy_o = st.pgm;
  assign flash_erase_req_o = st.erase_req;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // properties sleep while reset is high; the state is rebuilt then
  // helper terms below name the bus events the properties watch

  logic rd_plain; // plain rom-style read of a cell
  logic rd_blocked; // eeprom read during write mode
  logic rd_ctrl; // read of control/status
  logic lat_clear_req; // software tries to drop latch bit while busy
  assign rd_plain = rd_go & rd_ee & ~st.lat & ~st.rop;
  assign rd_blocked = rd_go & rd_ee & st.lat;
  assign rd_ctrl = rd_go & (araddr_i == CTRL_STATUS_ADDR);
  assign lat_clear_req = wr_go & (st.awaddr == CTRL_STATUS_ADDR)
    & st.wlane0 & st.pgm & st.wbyte[PGM_BIT] & ~st.wbyte[LAT_BIT]
    & ~prog_done & ~halt_i;

  // rom reads first; blocked and register reads come after the latch and cycle checks
  a_rom_read: assert property (
    rd_plain |=> rvalid_o && rdata_o == {24'h000000, $past(rd_mem_byte)}
      && rresp_o == RESP_OKAY)
    else $error("eeprom read did not return the cell");

  a_latch_and: assert property (
    capture |=> st.latch[$past(wr_lane)] ==
      ($past(lane_val) & $past(st.wbyte)))
    else $error("latch did not accumulate as AND");

  a_no_capture: assert property (
    (wr_go && wr_ee && !st.lat) |=> st.latch_used == $past(st.latch_used)
      && st.latch == $past(st.latch))
    else $error("write in read mode reached a latch");

  a_cycle_end: assert property (
    prog_done |=> !st.pgm && !st.lat && st.latch_used == '0)
    else $error("cycle end did not clear bits and latches");

  a_latch_fall: assert property (
    $fell(st.lat) |-> st.latch_used == '0)
    else $error("latches survived a falling latch bit");

  a_undriven_read: assert property (
    rd_blocked |=> rvalid_o && rdata_o == 32'h00000000)
    else $error("read in write mode drove data");

  a_reserved_zero: assert property (
    rd_ctrl |=> rdata_o[31:2] == 30'h00000000
      && rdata_o[PGM_BIT] == $past(st.pgm))
    else $error("control read shows reserved bits");

  a_lat_hold: assert property (
    lat_clear_req |=> st.lat && st.pgm)
    else $error("latch bit cleared while busy");

  a_wait_entry: assert property (
    (wait_req && !st.pgm) |=> wait_state_o && !prog_busy_o)
    else $error("idle wait entry was delayed");

  a_halt_stop: assert property (
    halt_i |=> !prog_busy_o && halt_state_o)
    else $error("halt did not stop programming");

  a_protect_write: assert property (
    (wr_go && wr_ee && st.rop && !prog_done) |=> bresp_o == RESP_SLVERR
      && st.latch_used == $past(st.latch_used))
    else $error("protected eeprom accepted a write");

  // timer loads the full duration on every start
  a_timer_load: assert property (
    $rose(st.pgm) |-> st.count == 32'(PROG_LEN))
    else $error("timer did not load the cycle length");

  // a write with the byte lane off leaves every latch alone
  a_lane_off: assert property (
    (wr_go && !st.wlane0 && !prog_done)
      |=> st.latch_used == $past(st.latch_used))
    else $error("write with lane off reached a latch");

  // wait stays off while a cycle keeps running
  a_wait_defer: assert property (
    (wait_req && st.pgm && !prog_done && !halt_i && !wr_go)
      |=> !wait_state_o && prog_busy_o)
    else $error("wait entered during programming");

  // removing protection leaves every cell erased
  a_erase_cells: assert property (
    st.erase_req |-> st.mem == {MEM_BYTES{ERASED_BYTE}})
    else $error("protection removal left cells unerased");

  // ***************************************************************
  // coverage
  // ***************************************************************
  // one finished row, accumulation, halt, erase, deferred wait
  c_program_done: cover property (prog_done);
  c_double_write: cover property (capture ##[1:20] capture);
  c_halt_busy: cover property (st.pgm && halt_i);
  c_erase: cover property (st.erase_req);
  c_wait_deferred: cover property (wait_req && st.pgm);

endmodule // data_eeprom_row_programmer

`default_nettype wire

//--- bench/cpu_bus_model.sv
// Purpose: cpu side AXI4-Lite master for the eeprom row programmer
// Assumes: slave answers in its own time, the bench bounds every wait
// Notes: tasks start right after a clock edge and end one edge after the response is sampled
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
  // clock
  input wire logic clk_sys_i,
  // write channels
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [11:0] awaddr_o,
  output logic wvalid_o,
  input wire logic wready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  input wire logic bvalid_i,
  output logic bready_o,
  input wire logic [1:0] bresp_i,
  // read channels
  output logic arvalid_o,
  input wire logic arready_i,
  output logic [11:0] araddr_o,
  input wire logic rvalid_i,
  output logic rready_o,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i
);
  // ***************************************************************
  // idle bus
  // ***************************************************************
  // released payload is inverted so stale values never look valid
  initial begin
    awvalid_o = 1'b0;
    awaddr_o = 12'h0;
    wvalid_o = 1'b0;
    wdata_o = 32'h0;
    wstrb_o = 4'h0;
    bready_o = 1'b0;
    arvalid_o = 1'b0;
    araddr_o = 12'h0;
    rready_o = 1'b0;
  end

  // one write; address and data offered together, each held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid_o <= 1'b1;
    awaddr_o <= a;
    wvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= s;
    bready_o <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_i);
      if (!aw_done && awready_i === 1'b1) begin
        aw_done = 1'b1;
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (!w_done && wready_i === 1'b1) begin
        w_done = 1'b1;
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
        wstrb_o <= ~s;
      end
    end
    do @(posedge clk_sys_i); while (bvalid_i !== 1'b1);
    resp = bresp_i;
    bready_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // one read; rready held high until the answer is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    arvalid_o <= 1'b1;
    araddr_o <= a;
    rready_o <= 1'b1;
    do @(posedge clk_sys_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    do @(posedge clk_sys_i); while (rvalid_i !== 1'b1);
    d = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask
endmodule // cpu_bus_model
`default_nettype wire

//--- bench/data_eeprom_row_programmer_tb.sv
// Purpose: self-checking bench for the data eeprom row programmer
// Assumes: short programming time through PROG_LEN
// Notes: random row data from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`default_nettype none

module data_eeprom_row_programmer_tb;
  import eeprom_row_pkg::*;
  // ***************************************************************
  // signals
  // ***************************************************************
  localparam int PLEN = 40; // short cycle keeps the run brief
  logic clk_sys, rst, wait_for_interrupt_instr, ahalt, halt, wait_st, halt_st, busy, erase_req;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd_val, used;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] exp_mem [256]; // expected cells
  logic [7:0] lat [32]; // expected latches
  int err_count, num_checks, cycles, erase_seen, run, last_len;

  data_eeprom_row_programmer #(.PROG_LEN(PLEN))
    i_data_eeprom_row_programmer (
    .clk_sys_i(clk_sys), .rst_i(rst),
    .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .awprot_i(3'h0), .wvalid_i(wvalid), .wready_o(wready),
    .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
    .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid),
    .arready_o(arready), .araddr_i(araddr), .arprot_i(3'h0),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
    .rresp_o(rresp), .wait_for_interrupt_instr_i(wait_for_interrupt_instr),
    .active_halt_i(ahalt), .halt_i(halt), .wait_state_o(wait_st),
    .halt_state_o(halt_st), .prog_busy_o(busy),
    .flash_erase_req_o(erase_req));

  cpu_bus_model i_cpu_bus_model (
    .clk_sys_i(clk_sys), .awvalid_o(awvalid), .awready_i(awready),
    .awaddr_o(awaddr), .wvalid_o(wvalid), .wready_i(wready),
    .wdata_o(wdata), .wstrb_o(wstrb), .bvalid_i(bvalid),
    .bready_o(bready), .bresp_i(bresp), .arvalid_o(arvalid),
    .arready_i(arready), .araddr_o(araddr), .rvalid_i(rvalid),
    .rready_o(rready), .rdata_i(rdata), .rresp_i(rresp));

  // ***************************************************************
  // clock, monitors, timeout
  // ***************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // busy length per cycle, erase pulses, hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    if (erase_req === 1'b1) begin
      erase_seen <= erase_seen + 1;
    end
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [11:0] ee_addr(input int i);
    return 12'h400 + 12'(4 * i); // one byte per word
  endfunction

  function automatic logic [7:0] acc(input logic [7:0] o, input logic [7:0] n);
    return o & n; // latches only ever lose ones
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    i_cpu_bus_model.wr(a, d, 4'h1, resp);
    check("bresp", {30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    i_cpu_bus_model.rd(a, rd_val, resp);
    check("rresp", {30'h0, resp}, {30'h0, er});
    check("rdata", rd_val, ed);
  endtask

  // write n+1 bytes into one row, program it, read the row back
  task automatic fill_row(input int row, input int n, input bit w);
    int lane;
    logic [7:0] d;
    used = 32'h0;
    wr_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    rd_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    for (int k = 0; k <= n; k++) begin
      lane = (k * 7) % 32; // all lanes when n is 32, lane 0 twice
      d = 8'($random(seed));
      lat[lane] = used[lane] ? acc(lat[lane], d) : d;
      used[lane] = 1'b1;
      wr_chk(ee_addr(row * 32 + lane), {24'h0, d}, RESP_OKAY);
    end
    rd_chk(ee_addr(row * 32), 32'h0, RESP_SLVERR);
    wr_chk(CTRL_STATUS_ADDR, 32'h3, RESP_OKAY);
    rd_chk(CTRL_STATUS_ADDR, 32'h3, RESP_OKAY);
    wr_chk(CTRL_STATUS_ADDR, 32'h1, RESP_OKAY);
    rd_chk(CTRL_STATUS_ADDR, 32'h3, RESP_OKAY);
    if (w) begin
      wait_for_interrupt_instr <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check("wait_state", {31'h0, wait_st}, 32'h0);
    end
    for (int t = 0; t < 200 && busy !== 1'b0; t++) @(posedge clk_sys);
    @(posedge clk_sys);
    check("busy_len", last_len, PLEN);
    if (w) begin
      check("wait_state", {31'h0, wait_st}, 32'h1);
      wait_for_interrupt_instr <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    rd_chk(CTRL_STATUS_ADDR, 32'h0, RESP_OKAY);
    for (int k = 0; k < 32; k++) begin
      if (used[k]) exp_mem[row * 32 + k] = lat[k];
      rd_chk(ee_addr(row * 32 + k), {24'h0, exp_mem[row * 32 + k]},
             RESP_OKAY);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    rst = 1'b1;
    wait_for_interrupt_instr = 1'b0;
    ahalt = 1'b0;
    halt = 1'b0;
    seed = 32'h7ec2;
    cycles = 0;
    run = 0;
    last_len = 0;
    erase_seen = 0;
    for (int i = 0; i < 256; i++) exp_mem[i] = ERASED_BYTE;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(CTRL_STATUS_ADDR, {24'h0, CTRL_STATUS_RESET}, RESP_OKAY);
    // byte lane 0 off: the write is answered but changes nothing
    i_cpu_bus_model.wr(CTRL_STATUS_ADDR, 32'h2, 4'he, resp);
    check("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    rd_chk(CTRL_STATUS_ADDR, 32'h0, RESP_OKAY);
    rd_chk(12'h100, 32'h0, RESP_DECERR);
    wr_chk(ee_addr(9), 32'h5a, RESP_OKAY);
    rd_chk(ee_addr(9), 32'h0, RESP_OKAY);
    fill_row(1, 32, 1'b0);
    fill_row(2, 5, 1'b1);
    // a latched byte dropped by the latch bit falling must not land
    wr_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    wr_chk(ee_addr(99), 32'h0f, RESP_OKAY);
    wr_chk(CTRL_STATUS_ADDR, 32'h0, RESP_OKAY);
    fill_row(3, 4, 1'b0);
    // idle wait entry through active halt
    ahalt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("wait_state", {31'h0, wait_st}, 32'h1);
    ahalt <= 1'b0;
    // halt aborts a running cycle at once
    wr_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    wr_chk(ee_addr(130), 32'h11, RESP_OKAY);
    wr_chk(CTRL_STATUS_ADDR, 32'h3, RESP_OKAY);
    halt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("busy", {31'h0, busy}, 32'h0);
    check("halt_state", {31'h0, halt_st}, 32'h1);
    halt <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wr_chk(CTRL_STATUS_ADDR, 32'h0, RESP_OKAY);
    // protection shields, removal erases every cell
    wr_chk(OPTION_ADDR, 32'h1, RESP_OKAY);
    rd_chk(ee_addr(32), 32'h0, RESP_SLVERR);
    wr_chk(ee_addr(40), 32'h1, RESP_SLVERR);
    wr_chk(OPTION_ADDR, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    check("erase_pulses", erase_seen, 32'h1);
    rd_chk(ee_addr(32), 32'h0, RESP_OKAY);
    // software abort keeps write mode; reset mid cycle clears all
    wr_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    wr_chk(CTRL_STATUS_ADDR, 32'h3, RESP_OKAY);
    wr_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    rd_chk(CTRL_STATUS_ADDR, 32'h2, RESP_OKAY);
    wr_chk(CTRL_STATUS_ADDR, 32'h3, RESP_OKAY);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(CTRL_STATUS_ADDR, 32'h0, RESP_OKAY);
    tally_and_finish;
  end
endmodule // data_eeprom_row_programmer_tb
`default_nettype wire
